// *** src/cgc_pkg.sv ***
// Constants, field layout and types for the codec global control registers
package cgc_pkg;
  // Register addresses carried in command bits 6:0
  localparam logic [6:0] ADDR_CLK_CE = 7'h25;
  localparam logic [6:0] ADDR_PCM = 7'h26;
  localparam logic [6:0] ADDR_RING = 7'h27;
  localparam logic [6:0] ADDR_STATUS = 7'h28;
  localparam logic [6:0] ADDR_BIDIR1 = 7'h29;
  localparam int CMD_DIR_BIT = 7;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  // Values after reset
  localparam logic [7:0] CLK_CE_RST = 8'h02;
  localparam logic [7:0] PCM_RST = 8'h00;
  localparam logic [7:0] RING_RST = 8'h06;
  localparam logic [7:0] BIDIR1_RST = 8'h00;
  // Field positions
  localparam int CE_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam int LAW_BIT = 7;
  localparam int VOICE_BIT = 6;
  localparam int DCLK_BIT = 5;
  localparam int EDGE_LSB = 3;
  localparam int OFFS_LSB = 0;
  localparam int OPI_BIT = 7;
  localparam int RSV_BIT = 6;
  localparam int IPI_BIT = 5;
  localparam int IS_BIT = 4;
  localparam int RTE_BIT = 3;
  localparam int OS_LSB = 0;
  localparam int DIR_LSB = 4;
  // Ring output choice codes
  localparam logic [2:0] OS_BIDIR1 = 3'h3;
  localparam logic [2:0] OS_BIDIR2 = 3'h4;
  localparam logic [2:0] OS_BIDIR3 = 3'h5;
  localparam logic [2:0] OS_OUT1 = 3'h6;
  localparam logic [2:0] OS_OUT2 = 3'h7;
  // Master clock codes
  localparam logic [3:0] MCLK_8192 = 4'h0;
  localparam logic [3:0] MCLK_4096 = 4'h1;
  localparam logic [3:0] MCLK_2048 = 4'h2;
  localparam logic [3:0] MCLK_1536 = 4'h6;
  localparam logic [3:0] MCLK_1544 = 4'he;
  localparam logic [3:0] MCLK_3072 = 4'h5;
  localparam logic [3:0] MCLK_3088 = 4'hd;
  localparam logic [3:0] MCLK_6144 = 4'h4;
  localparam logic [3:0] MCLK_6176 = 4'hc;
  // Debounce time and its cycle count at 25 MHz, rounded up
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEB_TIME_NS = 1000000;
  localparam int DEB_CYCLES = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    CGC_IDLE = 2'b00,
    CGC_CMD = 2'b01,
    CGC_WDATA = 2'b10,
    CGC_RDATA = 2'b11
  } cgc_phase_t;
endpackage

// *** src/cgc_debounce.sv ***
// Debouncer for a group of slow line-interface inputs
`timescale 1ns/1ps
module cgc_debounce #(
  parameter int W = 8,
  parameter int PERIOD = 25000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);
  typedef struct packed {
    logic [31:0] div;
    logic [W-1:0] samp;
    logic [W-1:0] clean;
  } cgc_deb_st_t;
  cgc_deb_st_t st_reg;
  cgc_deb_st_t st_next;

  // A bit moves only when two samples one period apart agree
  always_comb
  begin
    st_next = st_reg;
    if (st_reg.div >= 32'(PERIOD - 1))
    begin
      st_next.div = '0;
      st_next.samp = raw;
      for (int i = 0; i < W; i++)
      begin
        if (raw[i] == st_reg.samp[i])
          st_next.clean[i] = raw[i];
      end
    end
    else
      st_next.div = st_reg.div + 32'h1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign clean = st_reg.clean;
endmodule

// *** src/cgc_regs.sv ***
// Global control and status registers behind the serial command port
//
// Behaviour
// - Programming commands are accepted whatever the enable bits hold
// - Enable bits 7:4 gate channels, reset cleared
// - Low nibble selects master clock, reset 2.048
// - Command bit 7: zero reads, one writes
// - Bit 7 selects A-law or mu-law
// - Bit 6 selects compressed or linear code
// - Bit 5 selects single or double clock
// - Edge bits set transmit and receive edges
// - Offset bits delay slots 0-7 bit clocks
// - Ring polarity bit sets active output level
// - Hook polarity bit sets active input level
// - Hook choice bit picks first or second input
// - Ring trip enable bit, reset disabled
// - Ring choice field picks ring control pin
// - Status low nibble: debounced first inputs
// - Status high nibble: debounced second inputs
// - Bidir direction bits, zero input at reset
// - Input pins read back their current level
// - Output pins drive the written data bit, or the ring level when the ring choice field selects bidir1
`timescale 1ns/1ps
module cgc_regs #(
  parameter int DEB_CYCLES = cgc_pkg::DEB_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic cclk,
  input wire logic cdi,
  output logic cdo,
  output logic cdo_oe_b,
  output logic [3:0] prog_enable,
  output logic [3:0] mclk_sel,
  output logic mclk_valid,
  output logic law_mu,
  output logic voice_linear,
  output logic double_clk,
  output logic [1:0] pcm_edge,
  input wire logic bclk_tick,
  input wire logic frame_sync,
  output logic slot_start,
  input wire logic [3:0] ring_req,
  input wire logic [3:0] line_in_one,
  input wire logic [3:0] line_in_two,
  output logic [3:0] offhook,
  output logic [3:0] line_out_one,
  output logic [3:0] line_out_two,
  input wire logic [3:0] bidir_line_one_in,
  output logic [3:0] bidir_line_one_out,
  output logic [3:0] bidir_line_one_oe_b
);
  typedef struct packed {
    cgc_pkg::cgc_phase_t phase;
    logic cclk_d;
    logic fs_d;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] txsh;
    logic rd_drive;
    logic cdo;
    logic cdo_oe_b;
    logic [7:0] clk_ce;
    logic [7:0] pcm;
    logic [7:0] ring;
    logic [3:0] dir;
    logic [3:0] dat;
    logic mclk_valid;
    logic [2:0] slot_cnt;
    logic slot_arm;
    logic slot_start;
    logic [3:0] offhook;
    logic [3:0] out_one;
    logic [3:0] out_two;
    logic [3:0] bidir_out;
    logic [3:0] bidir_oe_b;
  } cgc_st_t;
  cgc_st_t st_reg;
  cgc_st_t st_next;
  logic [7:0] deb;
  logic [3:0] hook_src;
  logic [3:0] hook_act;
  logic [3:0] ring_act;
  logic [3:0] ring_lvl;
  logic [3:0] bidir_rd;
  logic [7:0] rd_val;
  logic rd_ok;
  logic cclk_rise;
  logic cclk_fall;
  logic [7:0] byte_in;
  logic wr_commit;
  logic [2:0] os;
  logic ring_drive_polarity;

  cgc_debounce #(
    .W(8),
    .PERIOD(DEB_CYCLES)
  ) u_deb (
    .clk(clk),
    .rst_b(rst_b),
    .raw({line_in_two, line_in_one}),
    .clean(deb)
  );

  assign cclk_rise = cclk && !st_reg.cclk_d;
  assign cclk_fall = !cclk && st_reg.cclk_d;
  assign byte_in = {st_reg.shreg[6:0], cdi};
  assign os = st_reg.ring[cgc_pkg::OS_LSB +: 3];
  assign ring_drive_polarity = st_reg.ring[cgc_pkg::OPI_BIT];
  assign wr_commit = (st_reg.phase == cgc_pkg::CGC_WDATA) && cclk_rise && !cs_b
    && (st_reg.bitcnt == cgc_pkg::BYTE_LAST);

  // Hook sense, ring trip and pin readback
  always_comb
  begin
    hook_src = st_reg.ring[cgc_pkg::IS_BIT] ? deb[7:4] : deb[3:0];
    hook_act = st_reg.ring[cgc_pkg::IPI_BIT] ? hook_src : ~hook_src;
    // Trip stops ringing on an off-hook channel only while trip is enabled
    ring_act = ring_req & ~({4{st_reg.ring[cgc_pkg::RTE_BIT]}} & hook_act);
    ring_lvl = ring_drive_polarity ? ~ring_act : ring_act;
    bidir_rd = (st_reg.dir & st_reg.dat) | (~st_reg.dir & bidir_line_one_in);
  end

  // Read decode; only addresses of this bank answer
  always_comb
  begin
    rd_ok = 1'b1;
    case (byte_in[6:0])
      cgc_pkg::ADDR_CLK_CE: rd_val = st_reg.clk_ce;
      cgc_pkg::ADDR_PCM: rd_val = st_reg.pcm;
      cgc_pkg::ADDR_RING: rd_val = st_reg.ring;
      cgc_pkg::ADDR_STATUS: rd_val = deb;
      cgc_pkg::ADDR_BIDIR1: rd_val = {st_reg.dir, bidir_rd};
      default:
      begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.cclk_d = cclk;
    st_next.fs_d = frame_sync;
    st_next.slot_start = 1'b0;
    if (cs_b)
    begin
      st_next.phase = cgc_pkg::CGC_IDLE;
      st_next.cdo_oe_b = 1'b1;
    end
    else
    begin
      case (st_reg.phase)
        cgc_pkg::CGC_IDLE:
        begin
          st_next.phase = cgc_pkg::CGC_CMD;
          st_next.bitcnt = 4'h0;
        end
        cgc_pkg::CGC_CMD:
        begin
          if (cclk_rise)
          begin
            st_next.shreg = byte_in;
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
            if (st_reg.bitcnt == cgc_pkg::BYTE_LAST)
            begin
              st_next.cmd = byte_in;
              st_next.bitcnt = 4'h0;
              if (byte_in[cgc_pkg::CMD_DIR_BIT])
                st_next.phase = cgc_pkg::CGC_WDATA;
              else
              begin
                st_next.phase = cgc_pkg::CGC_RDATA;
                st_next.txsh = rd_val;
                st_next.rd_drive = rd_ok;
              end
            end
          end
        end
        cgc_pkg::CGC_WDATA:
        begin
          if (cclk_rise)
          begin
            st_next.shreg = byte_in;
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
            if (st_reg.bitcnt == cgc_pkg::BYTE_LAST)
            begin
              st_next.phase = cgc_pkg::CGC_CMD;
              st_next.bitcnt = 4'h0;
              case (st_reg.cmd[6:0])
                cgc_pkg::ADDR_CLK_CE: st_next.clk_ce = byte_in;
                cgc_pkg::ADDR_PCM: st_next.pcm = byte_in;
                cgc_pkg::ADDR_RING:
                begin
                  st_next.ring = byte_in;
                  st_next.ring[cgc_pkg::RSV_BIT] = 1'b0;
                end
                cgc_pkg::ADDR_BIDIR1:
                begin
                  st_next.dir = byte_in[cgc_pkg::DIR_LSB +: 4];
                  st_next.dat = byte_in[3:0];
                end
                // Status is read only, other codes belong elsewhere
                default: st_next.ring = st_reg.ring;
              endcase
            end
          end
        end
        cgc_pkg::CGC_RDATA:
        begin
          // Data leaves on falling edges so the host samples on rising ones
          if (cclk_fall && st_reg.rd_drive)
          begin
            st_next.cdo = st_reg.txsh[7];
            st_next.txsh = {st_reg.txsh[6:0], 1'b0};
            st_next.cdo_oe_b = 1'b0;
          end
          if (cclk_rise)
          begin
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
            if (st_reg.bitcnt == cgc_pkg::BYTE_LAST)
            begin
              st_next.phase = cgc_pkg::CGC_CMD;
              st_next.bitcnt = 4'h0;
              st_next.cdo_oe_b = 1'b1;
            end
          end
        end
        default: st_next.phase = cgc_pkg::CGC_IDLE;
      endcase
    end

    case (st_next.clk_ce[cgc_pkg::SEL_LSB +: 4])
      cgc_pkg::MCLK_8192, cgc_pkg::MCLK_4096, cgc_pkg::MCLK_2048,
      cgc_pkg::MCLK_1536, cgc_pkg::MCLK_1544, cgc_pkg::MCLK_3072,
      cgc_pkg::MCLK_3088, cgc_pkg::MCLK_6144, cgc_pkg::MCLK_6176: st_next.mclk_valid = 1'b1;
      default: st_next.mclk_valid = 1'b0;
    endcase

    // Slot start trails the frame edge by the programmed bit clocks
    if (frame_sync && !st_reg.fs_d)
    begin
      if (st_reg.pcm[cgc_pkg::OFFS_LSB +: 3] == 3'h0)
        st_next.slot_start = 1'b1;
      else
      begin
        st_next.slot_cnt = st_reg.pcm[cgc_pkg::OFFS_LSB +: 3];
        st_next.slot_arm = 1'b1;
      end
    end
    else if (st_reg.slot_arm && bclk_tick)
    begin
      st_next.slot_cnt = st_reg.slot_cnt - 3'h1;
      if (st_reg.slot_cnt == 3'h1)
      begin
        st_next.slot_arm = 1'b0;
        st_next.slot_start = 1'b1;
      end
    end

    st_next.offhook = hook_act;
    // Idle selected pins and unselected pins rest at the inactive level
    st_next.out_one = (os == cgc_pkg::OS_OUT1) ? ring_lvl : {4{ring_drive_polarity}};
    st_next.out_two = (os == cgc_pkg::OS_OUT2) ? ring_lvl : {4{ring_drive_polarity}};
    // Ring on a bidir line only takes effect where it is an output
    st_next.bidir_out = (os == cgc_pkg::OS_BIDIR1) ? ring_lvl : st_next.dat;
    st_next.bidir_oe_b = ~st_next.dir;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.phase <= cgc_pkg::CGC_IDLE;
      st_reg.cdo_oe_b <= 1'b1;
      st_reg.clk_ce <= cgc_pkg::CLK_CE_RST;
      st_reg.pcm <= cgc_pkg::PCM_RST;
      st_reg.ring <= cgc_pkg::RING_RST;
      st_reg.dir <= cgc_pkg::BIDIR1_RST[7:4];
      st_reg.dat <= cgc_pkg::BIDIR1_RST[3:0];
      st_reg.bidir_oe_b <= ~cgc_pkg::BIDIR1_RST[7:4];
      st_reg.mclk_valid <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign cdo = st_reg.cdo;
  assign cdo_oe_b = st_reg.cdo_oe_b;
  assign prog_enable = st_reg.clk_ce[cgc_pkg::CE_LSB +: 4];
  assign mclk_sel = st_reg.clk_ce[cgc_pkg::SEL_LSB +: 4];
  assign mclk_valid = st_reg.mclk_valid;
  assign law_mu = st_reg.pcm[cgc_pkg::LAW_BIT];
  assign voice_linear = st_reg.pcm[cgc_pkg::VOICE_BIT];
  assign double_clk = st_reg.pcm[cgc_pkg::DCLK_BIT];
  assign pcm_edge = st_reg.pcm[cgc_pkg::EDGE_LSB +: 2];
  assign slot_start = st_reg.slot_start;
  assign offhook = st_reg.offhook;
  assign line_out_one = st_reg.out_one;
  assign line_out_two = st_reg.out_two;
  assign bidir_line_one_out = st_reg.bidir_out;
  assign bidir_line_one_oe_b = st_reg.bidir_oe_b;

  // Checks
  sequence s_write(logic [6:0] a);
    wr_commit && (st_reg.cmd[6:0] == a);
  endsequence
  property p_ce_write;
    @(posedge clk) disable iff (!rst_b)
      s_write(cgc_pkg::ADDR_CLK_CE) |=> prog_enable == $past(byte_in[7:4]);
  endproperty
  a_ce_write: assert property (p_ce_write) else $error("enable bits not written");
  property p_pcm_write;
    @(posedge clk) disable iff (!rst_b)
      s_write(cgc_pkg::ADDR_PCM) |=> {law_mu, voice_linear, double_clk, pcm_edge} == $past(byte_in[7:3]);
  endproperty
  a_pcm_write: assert property (p_pcm_write) else $error("pcm format not written");
  property p_read_no_change;
    @(posedge clk) disable iff (!rst_b)
      (st_reg.phase == cgc_pkg::CGC_RDATA) |=> $stable(st_reg.clk_ce) && $stable(st_reg.pcm);
  endproperty
  a_read_no_change: assert property (p_read_no_change) else $error("read changed a register");
  property p_reserved_zero;
    @(posedge clk) disable iff (!rst_b)
      s_write(cgc_pkg::ADDR_RING) |=> !st_reg.ring[cgc_pkg::RSV_BIT] ##1 !st_reg.ring[cgc_pkg::RSV_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
  property p_slot_zero;
    @(posedge clk) disable iff (!rst_b)
      (frame_sync && !st_reg.fs_d && st_reg.pcm[2:0] == 3'h0) |=> slot_start;
  endproperty
  a_slot_zero: assert property (p_slot_zero) else $error("slot start missing at zero offset");
  property p_slot_early;
    @(posedge clk) disable iff (!rst_b)
      (frame_sync && !st_reg.fs_d && st_reg.pcm[2:0] != 3'h0) |=> !slot_start;
  endproperty
  a_slot_early: assert property (p_slot_early) else $error("slot start too early");
  property p_offhook;
    @(posedge clk) disable iff (!rst_b)
      1'b1 |=> offhook == ($past(st_reg.ring[cgc_pkg::IS_BIT] ? deb[7:4] : deb[3:0])
        ^ {4{!$past(st_reg.ring[cgc_pkg::IPI_BIT])}});
  endproperty
  a_offhook: assert property (p_offhook) else $error("off-hook sense wrong");
  property p_out_one_ring;
    @(posedge clk) disable iff (!rst_b)
      (os == cgc_pkg::OS_OUT1 && $stable(os)) |=> line_out_one == $past(ring_lvl);
  endproperty
  a_out_one_ring: assert property (p_out_one_ring) else $error("ring pin not driven");
  property p_status_read;
    @(posedge clk) disable iff (!rst_b)
      (st_reg.phase == cgc_pkg::CGC_CMD && cclk_rise && !cs_b && st_reg.bitcnt == 4'h7
        && byte_in == {1'b0, cgc_pkg::ADDR_STATUS}) |=> st_reg.txsh == $past(deb);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_bidir_drive;
    @(posedge clk) disable iff (!rst_b)
      (os != cgc_pkg::OS_BIDIR1) |=> bidir_line_one_out == $past(st_next.dat);
  endproperty
  a_bidir_drive: assert property (p_bidir_drive) else $error("bidir data not driven");
endmodule

// *** test/cgc_host.sv ***
// Host model that drives the serial command port of the global control registers
`timescale 1ns/1ps
module cgc_host (
  input wire logic clk,
  output logic cs_b,
  output logic cclk,
  output logic cdi,
  input wire logic cdo,
  input wire logic cdo_oe_b
);
  initial
  begin
    cs_b = 1'b1;
    cclk = 1'b0;
    cdi = 1'b0;
  end

  // Command byte then n data bits; fewer than 8 data bits aborts the frame
  task automatic frame(input logic [7:0] c, input logic [7:0] d, input int n, output logic [7:0] r,
                       output logic oe);
    logic [15:0] s;
    s = {c, d};
    oe = 1'b1;
    r = 8'h00;
    @(posedge clk);
    cs_b <= 1'b0;
    for (int i = 15; i >= 8 - n; i--)
    begin
      @(posedge clk);
      cclk <= 1'b0;
      cdi <= s[i];
      repeat (3) @(posedge clk);
      if (i < 8)
      begin
        r[i] = cdo;
        oe = oe & ~cdo_oe_b;
      end
      cclk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    cs_b <= 1'b1;
    cclk <= 1'b0;
    // Released data line must not keep showing the last bit
    cdi <= ~cdi;
    repeat (2) @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic oe;
    frame({1'b1, a}, d, 8, r, oe);
  endtask
endmodule

// *** test/tb.sv ***
// Self-checking bench for the codec global control registers
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs_b, cclk, cdi, cdo, cdo_oe_b, mclk_valid, law_mu, voice_linear, double_clk, slot_start;
  logic bclk_tick = 1'b0;
  logic frame_sync = 1'b0;
  logic [3:0] prog_enable, mclk_sel, offhook, line_out_one, line_out_two, b_out, b_oe_b, b_pin;
  logic [3:0] ring_req = 4'hf;
  logic [3:0] line_in_one = 4'h5;
  logic [3:0] line_in_two = 4'h3;
  logic [3:0] ext = 4'hf;
  logic [1:0] pcm_edge;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  // Pin level: the design wins where it drives, the far side elsewhere
  assign b_pin = (b_out & ~b_oe_b) | (ext & b_oe_b);

  always #20 clk = ~clk;

  cgc_host host (.clk(clk), .cs_b(cs_b), .cclk(cclk), .cdi(cdi), .cdo(cdo), .cdo_oe_b(cdo_oe_b));

  cgc_regs #(.DEB_CYCLES(4)) uut (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .cclk(cclk), .cdi(cdi), .cdo(cdo), .cdo_oe_b(cdo_oe_b),
    .prog_enable(prog_enable), .mclk_sel(mclk_sel), .mclk_valid(mclk_valid), .law_mu(law_mu),
    .voice_linear(voice_linear), .double_clk(double_clk), .pcm_edge(pcm_edge), .bclk_tick(bclk_tick),
    .frame_sync(frame_sync), .slot_start(slot_start), .ring_req(ring_req), .line_in_one(line_in_one),
    .line_in_two(line_in_two), .offhook(offhook), .line_out_one(line_out_one), .line_out_two(line_out_two),
    .bidir_line_one_in(b_pin), .bidir_line_one_out(b_out), .bidir_line_one_oe_b(b_oe_b)
  );

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Bench run is a few thousand cycles; this ceiling only catches a hang
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] r;
    logic o;
    host.frame({1'b0, a}, 8'h00, 8, r, o);
    chk(r, exp);
    chk(o, 1'b1);
  endtask

  task automatic settle;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_reset;
    chk(prog_enable, 4'h0);
    chk({law_mu, voice_linear, double_clk, pcm_edge}, 5'h00);
    chk(b_oe_b, 4'hf);
    rdc(cgc_pkg::ADDR_CLK_CE, 8'h02);
    rdc(cgc_pkg::ADDR_PCM, 8'h00);
    rdc(cgc_pkg::ADDR_RING, 8'h06);
    rdc(cgc_pkg::ADDR_BIDIR1, 8'h0f);
  endtask

  task automatic t_clk_ce;
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'he, 4'h5, 4'hd, 4'h4, 4'hc};
    for (int i = 0; i < 9; i++)
    begin
      host.wr(cgc_pkg::ADDR_CLK_CE, {codes[i], codes[i]});
      settle();
      chk(prog_enable, codes[i]);
      chk(mclk_sel, codes[i]);
      chk(mclk_valid, 1'b1);
    end
    host.wr(cgc_pkg::ADDR_CLK_CE, 8'h83);
    settle();
    chk({prog_enable, mclk_sel}, 8'h83);
    chk(mclk_valid, 1'b0);
    rdc(cgc_pkg::ADDR_CLK_CE, 8'h83);
  endtask

  task automatic t_pcm;
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = {i[0], i[1], i[0], i[1:0], 3'h0};
      host.wr(cgc_pkg::ADDR_PCM, v);
      settle();
      chk({law_mu, voice_linear, double_clk, pcm_edge}, v[7:3]);
      rdc(cgc_pkg::ADDR_PCM, v);
    end
  endtask

  // Slot start must follow the frame edge by exactly k bit-clock ticks
  task automatic t_slot(input logic [2:0] k);
    int ticks = 0;
    int seen = -1;
    int hits = 0;
    host.wr(cgc_pkg::ADDR_PCM, {5'h00, k});
    for (int c = 0; c < 40; c++)
    begin
      @(posedge clk);
      frame_sync <= (c < 20);
      bclk_tick <= (c % 4 == 3);
      @(negedge clk);
      if (slot_start === 1'b1)
      begin
        hits++;
        seen = ticks;
      end
      if (c % 4 == 3)
        ticks++;
    end
    // The last loop pass leaves the tick raised; a one-cycle enable must fall again
    @(posedge clk);
    bclk_tick <= 1'b0;
    chk(8'(hits), 8'h01);
    chk(8'(seen), {5'h00, k});
  endtask

  task automatic t_ring;
    // Ring value, off-hook, first out, second out, bidir out; inputs 5 and 3, requests f
    logic [23:0] tab [4] = '{24'h06af00, 24'h2e5a00, 24'h9fcfc0, 24'h4ba005};
    for (int i = 0; i < 4; i++)
    begin
      host.wr(cgc_pkg::ADDR_RING, tab[i][23:16]);
      settle();
      chk(offhook, tab[i][15:12]);
      chk({line_out_one, line_out_two}, tab[i][11:4]);
      if (tab[i][18:16] == cgc_pkg::OS_BIDIR1)
        chk(b_out, tab[i][3:0]);
      rdc(cgc_pkg::ADDR_RING, tab[i][23:16] & 8'hbf);
    end
    host.wr(cgc_pkg::ADDR_RING, 8'h06);
    @(posedge clk);
    ring_req <= 4'h9;
    settle();
    chk(line_out_one, 4'h9);
    rdc(cgc_pkg::ADDR_STATUS, 8'h35);
    host.wr(cgc_pkg::ADDR_STATUS, 8'hff);
    rdc(cgc_pkg::ADDR_STATUS, 8'h35);
  endtask

  task automatic t_bidir;
    host.wr(cgc_pkg::ADDR_BIDIR1, 8'h5a);
    settle();
    chk(b_oe_b, 4'ha);
    chk(b_pin, 4'ha);
    rdc(cgc_pkg::ADDR_BIDIR1, 8'h5a);
    @(posedge clk);
    ext <= 4'h0;
    settle();
    rdc(cgc_pkg::ADDR_BIDIR1, 8'h50);
    host.wr(cgc_pkg::ADDR_BIDIR1, 8'hf5);
    settle();
    chk({b_oe_b, b_pin}, 8'h05);
  endtask

  task automatic t_refuse;
    logic [7:0] r;
    logic o;
    host.frame(8'h7f, 8'h00, 8, r, o);
    chk(o, 1'b0);
    // Write of the format register cut short after three data bits
    host.frame(8'ha6, 8'hff, 3, r, o);
    rdc(cgc_pkg::ADDR_PCM, 8'h07);
    chk(law_mu, 1'b0);
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (16) @(posedge clk);
    t_reset();
    t_clk_ce();
    t_pcm();
    t_slot(3'h0);
    t_slot(3'h3);
    t_slot(3'h7);
    t_ring();
    t_bidir();
    t_refuse();
    close_out();
  end
endmodule
